/* File: core/dpc_if.sv */
/*
 Register access carrier between the serial slave and the register bank.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface dpc_if;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic [7:0] rdata;

    modport spi  (output addr, output wdata, output wr, input rdata);
    modport regs (input addr, input wdata, input wr, output rdata);
endinterface

`default_nettype wire

/* File: core/dpc_map.svh */
/*
 Register offsets, field positions, reset values and frame counts
 for the driver power control block.
 Assumes a 7-bit register space of 8-bit registers reached by 16-bit serial frames.
*/
`ifndef DPC_MAP_SVH
`define DPC_MAP_SVH

`define DPC_OFS_DRV_CTRL    7'h00
`define DPC_OFS_PWR_CTRL    7'h01
`define DPC_OFS_TRIM        7'h04
`define DPC_OFS_PART_ID     7'h7e
`define DPC_OFS_REV         7'h7f

`define DPC_BIT_DRV_SLEEP_N 4
`define DPC_BIT_CONV_SLEEP  0
`define DPC_BIT_KEEP_CONV   1
`define DPC_BIT_SHDN_STAT   2
`define DPC_BIT_SOFT_RST    7

`define DPC_RST_DRV_SLEEP_N 1'b1
`define DPC_RST_CONV_SLEEP  1'b1
`define DPC_RST_KEEP_CONV   1'b0
`define DPC_RST_TRIM        8'h00

`define DPC_TRIM_STARVED    8'h7f
`define DPC_TRIM_MAG_ZERO   7'h00

`define DPC_CMD_LAST_BIT    5'h07
`define DPC_FRAME_LAST_BIT  5'h0f

`endif

/* File: core/dpc_pkg.sv */
/*
 Types shared by the driver power control block.
 Assumes dpc_map.svh supplies the numeric constants.
*/
package dpc_pkg;

    // Frame phases, Gray coded along command, data, done
    typedef enum logic [1:0] {
        DPC_PH_CMD  = 2'b00,
        DPC_PH_DATA = 2'b01,
        DPC_PH_DONE = 2'b11
    } dpc_phase_t;

    typedef struct packed {
        logic       dir;
        logic [6:0] mag;
    } dpc_trim_t;

endpackage

/* File: core/dpc_regs.sv */
/*
 Driver power control register bank behind the serial port.
 Assumes synchronous pins and a shutdown pin seen as two sensed levels.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dpc_map.svh"

module dpc_regs #(
    parameter logic [7:0] PART_ID  = 8'h5a,  // Arbitrary value
    parameter logic [3:0] REV_CODE = 4'h3    // Arbitrary value
) (
    // Clock and reset
    input  wire logic       CLK,
    input  wire logic       RESETN,
    // Serial port
    input  wire logic       CS_N,
    input  wire logic       SCLK,
    input  wire logic       SDI,
    output logic            SDO_O,
    output logic            SDO_OE,
    // Shutdown pin levels
    input  wire logic       SHDN_PIN_HIGH,
    input  wire logic       SHDN_PIN_LOW,
    // Power controls
    output logic            DRIVER_ACTIVE,
    output logic            CONVERTER_ON,
    output logic            SHUTDOWN_LATCHED,
    // Bias current trim
    output logic            BIAS_TRIM_DIR,
    output logic [6:0]      BIAS_TRIM_MAG,
    output logic            BIAS_NOMINAL,
    output logic            BIAS_STARVED
);
    dpc_if bus ();

    logic                drv_sleep_n_q;
    logic                conv_sleep_q;
    logic                keep_conv_q;
    logic                soft_rst_q;
    logic                shdn_q;
    dpc_pkg::dpc_trim_t  trim_q;
    logic                drv_active_q;
    logic                conv_on_q;
    logic                nominal_q;
    logic                starved_q;
    logic                wr_drv;
    logic                wr_pwr;
    logic                wr_trim;
    logic                clr;

    dpc_spi_slave u_spi (
        .clk    (CLK),
        .rst_n  (RESETN),
        .cs_n   (CS_N),
        .sclk   (SCLK),
        .sdi    (SDI),
        .sdo_o  (SDO_O),
        .sdo_oe (SDO_OE),
        .bus    (bus)
    );

    assign wr_drv  = bus.wr && bus.addr == `DPC_OFS_DRV_CTRL;
    assign wr_pwr  = bus.wr && bus.addr == `DPC_OFS_PWR_CTRL;
    assign wr_trim = bus.wr && bus.addr == `DPC_OFS_TRIM;
    // Soft reset acts one cycle after its write; the pin reset clears at once
    assign clr     = !RESETN || soft_rst_q;

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            soft_rst_q <= 1'b0;
        end else begin
            soft_rst_q <= wr_pwr && bus.wdata[`DPC_BIT_SOFT_RST];
        end
    end

    // Only serial writes and resets touch the sleep bit
    always_ff @(posedge CLK) begin
        if (clr) begin
            drv_sleep_n_q <= `DPC_RST_DRV_SLEEP_N;
        end else if (wr_drv) begin
            drv_sleep_n_q <= bus.wdata[`DPC_BIT_DRV_SLEEP_N];
        end
    end

    always_ff @(posedge CLK) begin
        if (clr) begin
            conv_sleep_q <= `DPC_RST_CONV_SLEEP;
            keep_conv_q  <= `DPC_RST_KEEP_CONV;
        end else if (wr_pwr) begin
            conv_sleep_q <= bus.wdata[`DPC_BIT_CONV_SLEEP];
            keep_conv_q  <= bus.wdata[`DPC_BIT_KEEP_CONV];
        end
    end

    always_ff @(posedge CLK) begin
        if (clr) begin
            trim_q <= `DPC_RST_TRIM;
        end else if (wr_trim) begin
            trim_q <= bus.wdata;
        end
    end

    // Latch survives a floating pin; soft reset leaves it alone so a
    // stray register reset cannot re-enable a faulted driver.
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            shdn_q <= 1'b0;
        end else if (SHDN_PIN_HIGH) begin
            shdn_q <= 1'b1;
        end else if (SHDN_PIN_LOW) begin
            shdn_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            drv_active_q <= 1'b0;
            conv_on_q    <= 1'b0;
        end else begin
            drv_active_q <= drv_sleep_n_q && !shdn_q;
            conv_on_q    <= !conv_sleep_q
                            && !(shdn_q && !keep_conv_q);
        end
    end

    // Both code halves start at nominal; only the magnitude moves it
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            nominal_q <= 1'b1;
            starved_q <= 1'b0;
        end else begin
            nominal_q <= trim_q.mag == `DPC_TRIM_MAG_ZERO;
            starved_q <= trim_q == `DPC_TRIM_STARVED;
        end
    end

    always_comb begin
        if (bus.addr == `DPC_OFS_DRV_CTRL) begin
            bus.rdata = 8'h00;
            bus.rdata[`DPC_BIT_DRV_SLEEP_N] = drv_sleep_n_q;
        end else if (bus.addr == `DPC_OFS_PWR_CTRL) begin
            bus.rdata = 8'h00;
            bus.rdata[`DPC_BIT_CONV_SLEEP] = conv_sleep_q;
            bus.rdata[`DPC_BIT_KEEP_CONV]  = keep_conv_q;
            bus.rdata[`DPC_BIT_SHDN_STAT]  = shdn_q;
        end else if (bus.addr == `DPC_OFS_TRIM) begin
            bus.rdata = trim_q;
        end else if (bus.addr == `DPC_OFS_PART_ID) begin
            bus.rdata = PART_ID;
        end else if (bus.addr == `DPC_OFS_REV) begin
            bus.rdata = {4'h0, REV_CODE};
        end else begin
            bus.rdata = 8'h00;
        end
    end

    assign DRIVER_ACTIVE    = drv_active_q;
    assign CONVERTER_ON     = conv_on_q;
    assign SHUTDOWN_LATCHED = shdn_q;
    assign BIAS_TRIM_DIR    = trim_q.dir;
    assign BIAS_TRIM_MAG    = trim_q.mag;
    assign BIAS_NOMINAL     = nominal_q;
    assign BIAS_STARVED     = starved_q;

    a_sleep_enters: assert property (
        @(posedge CLK) disable iff (!RESETN)
        wr_drv && !bus.wdata[`DPC_BIT_DRV_SLEEP_N] ##1 !soft_rst_q
        |=> !DRIVER_ACTIVE)
        else $error("Driver still active after sleep write");

    a_sleep_exits: assert property (
        @(posedge CLK) disable iff (!RESETN)
        wr_drv && bus.wdata[`DPC_BIT_DRV_SLEEP_N] ##1 !shdn_q
        |=> DRIVER_ACTIVE)
        else $error("Driver not restored after wake write");

    a_sleep_spi_only: assert property (
        @(posedge CLK) disable iff (!RESETN)
        $changed(drv_sleep_n_q) |-> $past(wr_drv || clr))
        else $error("Driver sleep bit moved without a write");

    a_conv_sleep_off: assert property (
        @(posedge CLK) disable iff (!RESETN)
        conv_sleep_q |=> !CONVERTER_ON)
        else $error("Converter on while asleep");

    a_conv_reset_asleep: assert property (
        @(posedge CLK) disable iff (!RESETN)
        $rose(RESETN) |-> conv_sleep_q && !CONVERTER_ON)
        else $error("Converter not asleep after reset");

    a_conv_with_shdn: assert property (
        @(posedge CLK) disable iff (!RESETN)
        shdn_q && !keep_conv_q |=> !CONVERTER_ON && !DRIVER_ACTIVE)
        else $error("Converter left on through shutdown");

    a_conv_kept_on: assert property (
        @(posedge CLK) disable iff (!RESETN)
        shdn_q && keep_conv_q && !conv_sleep_q
        |=> CONVERTER_ON && !DRIVER_ACTIVE)
        else $error("Keep-alive converter not held on");

    a_part_id_fixed: assert property (
        @(posedge CLK) disable iff (!RESETN)
        bus.addr == `DPC_OFS_PART_ID |-> bus.rdata == PART_ID)
        else $error("Part identifier read wrong");

    a_rev_fixed: assert property (
        @(posedge CLK) disable iff (!RESETN)
        bus.addr == `DPC_OFS_REV |-> bus.rdata == {4'h0, REV_CODE})
        else $error("Revision read wrong");

    a_trim_nominal: assert property (
        @(posedge CLK) disable iff (!RESETN)
        wr_trim ##1 !clr ##1 1'b1 |-> BIAS_NOMINAL
        == ($past(bus.wdata, 2) inside {8'h00, 8'h80}))
        else $error("Nominal flag disagrees with trim code");

    a_soft_defaults: assert property (
        @(posedge CLK) disable iff (!RESETN)
        soft_rst_q |=> trim_q == `DPC_RST_TRIM && drv_sleep_n_q
        && conv_sleep_q && !keep_conv_q)
        else $error("Soft reset left a control off default");

    a_shdn_holds: assert property (
        @(posedge CLK) disable iff (!RESETN)
        shdn_q && !SHDN_PIN_LOW |=> shdn_q [*1] ##0 !DRIVER_ACTIVE)
        else $error("Shutdown released without low pin");

    a_trim_holds: assert property (
        @(posedge CLK) disable iff (!RESETN)
        !wr_trim && !soft_rst_q |=> $stable(trim_q))
        else $error("Trim changed without a write");
endmodule

`default_nettype wire

/* File: core/dpc_spi_slave.sv */
/*
 Serial slave: 16-bit frames, read flag, 7-bit address, 8-bit data.
 Assumes serial pins synchronous to clk, clock idle low, MSB first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dpc_map.svh"

module dpc_spi_slave (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Serial pins
    input  wire logic cs_n,
    input  wire logic sclk,
    input  wire logic sdi,
    output logic      sdo_o,
    output logic      sdo_oe,
    // Register side
    dpc_if.spi        bus
);
    logic                 sclk_q;
    logic [4:0]           cnt_q;
    logic [6:0]           sh_q;
    logic [7:0]           out_q;
    logic                 rd_q;
    logic                 load_q;
    logic [6:0]           addr_q;
    logic [7:0]           wdata_q;
    logic                 wr_q;
    dpc_pkg::dpc_phase_t  ph_q;
    logic                 rise;
    logic                 fall;

    assign rise = sclk & ~sclk_q;
    assign fall = ~sclk & sclk_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= sclk;
        end
    end

    // Frame framing; chip select high always restarts a frame
    always_ff @(posedge clk) begin
        if (!rst_n || cs_n) begin
            cnt_q  <= 5'h00;
            sh_q   <= 7'h00;
            ph_q   <= dpc_pkg::DPC_PH_CMD;
            rd_q   <= 1'b0;
            addr_q <= 7'h00;
            load_q <= 1'b0;
        end else if (rise && ph_q != dpc_pkg::DPC_PH_DONE) begin
            sh_q  <= {sh_q[5:0], sdi};
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == `DPC_CMD_LAST_BIT) begin
                rd_q   <= sh_q[6];
                addr_q <= {sh_q[5:0], sdi};
                load_q <= 1'b1;
                ph_q   <= dpc_pkg::DPC_PH_DATA;
            end else if (cnt_q == `DPC_FRAME_LAST_BIT) begin
                ph_q <= dpc_pkg::DPC_PH_DONE;
            end
        end else if (fall) begin
            load_q <= 1'b0;
        end
    end

    // Write strobe only at the close of a whole write frame
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_q    <= 1'b0;
            wdata_q <= 8'h00;
        end else begin
            wr_q <= 1'b0;
            if (!cs_n && rise && ph_q == dpc_pkg::DPC_PH_DATA
                && cnt_q == `DPC_FRAME_LAST_BIT) begin
                wdata_q <= {sh_q, sdi};
                wr_q    <= ~rd_q;
            end
        end
    end

    // Read data loads on the falling edge after the address byte
    always_ff @(posedge clk) begin
        if (!rst_n || cs_n) begin
            out_q <= 8'h00;
        end else if (fall) begin
            if (load_q) begin
                out_q <= bus.rdata;
            end else begin
                out_q <= {out_q[6:0], 1'b0};
            end
        end
    end

    assign bus.addr  = addr_q;
    assign bus.wdata = wdata_q;
    assign bus.wr    = wr_q;
    assign sdo_o     = out_q[7];
    assign sdo_oe    = ~cs_n;
endmodule

`default_nettype wire

/* File: sim/dpc_host_model.sv */
/*
 Serial host model that sends whole 16-bit frames to the register bank.
 Assumes a mode 0 port with SCLK idle low, two CLK cycles per SCLK level.
*/
`timescale 1ns/1ps
`default_nettype none

module dpc_host_model (
    // Clock
    input  wire logic clk,
    // Serial pins
    output var  logic cs_n,
    output var  logic sclk,
    output var  logic sdi,
    input  wire logic sdo,
    input  wire logic sdo_oe
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdi  = 1'b0;
    end

    // SCLK only moves inside a frame; SDO is taken on each of the last eight rises
    task automatic xfer(input logic rd, input logic [6:0] a,
                        input logic [7:0] wd, output logic [7:0] q);
        logic [15:0] f;
        f = {rd, a, wd};
        q = 8'h00;
        @(negedge clk);
        cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            sdi = f[i];
            repeat (2) @(negedge clk);
            sclk = 1'b1;
            if (i < 8) begin
                q[i] = sdo_oe ? sdo : 1'bx;
            end
            repeat (2) @(negedge clk);
            sclk = 1'b0;
        end
        repeat (2) @(negedge clk);
        cs_n = 1'b1;
        // Released data line must not look like the last bit
        sdi = ~sdi;
        repeat (3) @(negedge clk);
    endtask
endmodule

`default_nettype wire

/* File: sim/dpc_regs_bench.sv */
/*
 Self-checking bench for the driver power control register bank.
 Assumes dpc_host_model drives the serial pins, shutdown pin levels here.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dpc_map.svh"

module dpc_regs_bench;
    localparam logic [7:0] ID_VAL  = 8'ha7; // Arbitrary value
    localparam logic [3:0] REV_VAL = 4'hc;  // Arbitrary value

    logic       clk, resetn, cs_n, sclk, sdi, sdo_o, sdo_oe;
    logic       shdn_hi, shdn_lo, drv_act, conv_on, shdn_lat;
    logic       trim_dir, nominal, starved;
    logic [6:0] trim_mag;
    int         n_fail, n_tests;
    logic [7:0] codes [5] = '{8'h00, 8'h7f, 8'h80, 8'hff, 8'h41};
    logic [7:0] c;

    dpc_regs #(.PART_ID(ID_VAL), .REV_CODE(REV_VAL)) dut (
        .CLK(clk), .RESETN(resetn), .CS_N(cs_n), .SCLK(sclk),
        .SDI(sdi), .SDO_O(sdo_o), .SDO_OE(sdo_oe),
        .SHDN_PIN_HIGH(shdn_hi), .SHDN_PIN_LOW(shdn_lo),
        .DRIVER_ACTIVE(drv_act), .CONVERTER_ON(conv_on),
        .SHUTDOWN_LATCHED(shdn_lat), .BIAS_TRIM_DIR(trim_dir),
        .BIAS_TRIM_MAG(trim_mag), .BIAS_NOMINAL(nominal),
        .BIAS_STARVED(starved)
    );

    dpc_host_model u_host (
        .clk(clk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
        .sdo(sdo_o), .sdo_oe(sdo_oe)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic tally_and_finish;
        $display("Checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] exp,
                       input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Single-bit outputs share the byte compare so X still fails
    task automatic chk1(input string nm, input logic e, input logic g);
        chk(nm, {7'h0, e}, {7'h0, g});
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] q;
        u_host.xfer(1'b0, a, d, q);
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] q;
        u_host.xfer(1'b1, a, 8'h00, q);
        chk($sformatf("register %h", a), exp, q);
    endtask

    task automatic outs(input logic da, input logic co, input logic sl);
        chk1("DRIVER_ACTIVE", da, drv_act);
        chk1("CONVERTER_ON", co, conv_on);
        chk1("SHUTDOWN_LATCHED", sl, shdn_lat);
    endtask

    // Pin levels, then time for latch and outputs to follow
    task automatic pin(input logic hi, input logic lo);
        @(negedge clk);
        shdn_hi = hi;
        shdn_lo = lo;
        repeat (3) @(negedge clk);
    endtask

    task automatic do_reset;
        resetn = 1'b0;
        repeat (3) @(negedge clk);
        resetn = 1'b1;
        repeat (4) @(negedge clk);
    endtask

    initial begin
        resetn  = 1'b0;
        shdn_hi = 1'b0;
        shdn_lo = 1'b0;
        n_fail  = 0;
        n_tests = 0;
        do_reset();
        outs(1'b1, 1'b0, 1'b0);
        rd(`DPC_OFS_DRV_CTRL, 8'h10);
        rd(`DPC_OFS_PWR_CTRL, 8'h01);
        rd(`DPC_OFS_TRIM, 8'h00);
        // Driver sleep and wake, then converter wake
        wr(`DPC_OFS_DRV_CTRL, 8'h00);
        outs(1'b0, 1'b0, 1'b0);
        rd(`DPC_OFS_DRV_CTRL, 8'h00);
        wr(`DPC_OFS_DRV_CTRL, 8'h10);
        outs(1'b1, 1'b0, 1'b0);
        wr(`DPC_OFS_PWR_CTRL, 8'h00);
        outs(1'b1, 1'b1, 1'b0);
        // Default shutdown, held while the pin floats
        pin(1'b1, 1'b0);
        pin(1'b0, 1'b0);
        outs(1'b0, 1'b0, 1'b1);
        rd(`DPC_OFS_PWR_CTRL, 8'h04);
        // The pin stops the driver without touching the sleep bit
        rd(`DPC_OFS_DRV_CTRL, 8'h10);
        pin(1'b0, 1'b1);
        pin(1'b0, 1'b0);
        outs(1'b1, 1'b1, 1'b0);
        // Converter kept alive through a shutdown
        wr(`DPC_OFS_PWR_CTRL, 8'h02);
        pin(1'b1, 1'b0);
        pin(1'b0, 1'b0);
        outs(1'b0, 1'b1, 1'b1);
        pin(1'b0, 1'b1);
        pin(1'b0, 1'b0);
        wr(`DPC_OFS_PWR_CTRL, 8'h01);
        outs(1'b1, 1'b0, 1'b0);
        // Read-only codes and an unmapped place
        rd(`DPC_OFS_PART_ID, ID_VAL);
        wr(`DPC_OFS_PART_ID, 8'hff);
        rd(`DPC_OFS_PART_ID, ID_VAL);
        rd(`DPC_OFS_REV, {4'h0, REV_VAL});
        wr(7'h05, 8'hff);
        rd(7'h05, 8'h00);
        // Trim boundary codes on both polarities
        for (int k = 0; k < 5; k++) begin
            c = codes[k];
            wr(`DPC_OFS_TRIM, c);
            chk1("BIAS_TRIM_DIR", c[7], trim_dir);
            chk("BIAS_TRIM_MAG", {1'b0, c[6:0]}, {1'b0, trim_mag});
            chk1("BIAS_NOMINAL", c[6:0] == 7'h00, nominal);
            chk1("BIAS_STARVED", c == 8'h7f, starved);
            rd(`DPC_OFS_TRIM, c);
        end
        // Soft reset restores every control default
        wr(`DPC_OFS_DRV_CTRL, 8'h00);
        wr(`DPC_OFS_PWR_CTRL, 8'h02);
        wr(`DPC_OFS_PWR_CTRL, 8'h80);
        outs(1'b1, 1'b0, 1'b0);
        rd(`DPC_OFS_PWR_CTRL, 8'h01);
        rd(`DPC_OFS_TRIM, 8'h00);
        // Reset pin in mid-run
        wr(`DPC_OFS_TRIM, 8'hff);
        wr(`DPC_OFS_DRV_CTRL, 8'h00);
        do_reset();
        outs(1'b1, 1'b0, 1'b0);
        rd(`DPC_OFS_TRIM, 8'h00);
        tally_and_finish();
    end

    // About 35 frames of 70 cycles; generous margin
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        tally_and_finish();
    end
endmodule

`default_nettype wire
